// file: asbla_pkg.sv
// Constants, types and timing for the asynchronous SRAM host controller.
// Assumes one 10 MHz core clock and a memory wired straight to the pins.
//
// Summary of operation
// RULE1 - Word mode: 2M sixteen-bit words, 21-bit address
// RULE2 - Standby when deselected or both lanes off; in byte mode the model ignores the lanes, which the host holds off
// RULE3 - Memory data floats unless selected enabled read
// RULE4 - Write: select low, select high, strobe low
// RULE5 - Lower lane enable low stores data bits 0-7
// RULE6 - Upper lane enable low stores data bits 8-15
// RULE7 - Read: selects active, output enable low, strobe high
// RULE8 - Lower lane enable low drives bits 0-7
// RULE9 - Upper lane enable low drives bits 8-15
// RULE10 - Width strap high gives sixteen-bit word mode
// RULE11 - Strap low: byte mode, top pin is address
// RULE12 - Disabled lane keeps contents during word write
package asbla_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int DATA_W      = 16;
    localparam int WORD_ADDR_W = 21;
    localparam int ADDR_W      = 22;
    localparam int LANE_W      = 2;
    localparam int BYTE_W      = 8;
    localparam int TOP_BIT     = 15;
    localparam int SYNC_STAGES = 2;
    localparam int CNT_W       = 3;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int ACCESS_NS     = 55;
    localparam int WR_PULSE_NS   = 45;
    localparam int ACCESS_CYC    = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_PULSE_CYC  = (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] RD_LAST_CNT = CNT_W'(ACCESS_CYC + SYNC_STAGES - 1);
    localparam logic [CNT_W-1:0] WR_LAST_CNT = CNT_W'(WR_PULSE_CYC - 1);

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
    localparam logic [DATA_W-1:0] OE_N_OFF  = 16'hffff;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_RD_ACT,
        ST_WR_SETUP,
        ST_WR_PULSE,
        ST_WR_HOLD
    } asbla_state_e;

endpackage : asbla_pkg

// file: asbla_sync.sv
// Two-flop synchroniser for the memory data pins.
// Assumes the pins are stable for at least one clock around sampling.
`timescale 1ns/100ps
module asbla_sync
#(
    parameter int WIDTH = 16
)
(
    input  wire logic             core_clk_in,
    input  wire logic             reset_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // ************************************************************
    // Two stages
    // ************************************************************
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            meta_reg <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule : asbla_sync

// file: asbla_host.sv
// Host controller driving an asynchronous SRAM through its pins.
// Assumes the memory pins connect directly; data pins resolved outside.
`timescale 1ns/100ps
module asbla_host
(
    input  wire logic                            core_clk_in,
    input  wire logic                            reset_in,
    input  wire logic                            width_word_in,
    input  wire logic                            cmd_valid_in,
    input  wire logic                            cmd_write_in,
    input  wire logic [asbla_pkg::ADDR_W-1:0]    cmd_addr_in,
    input  wire logic [asbla_pkg::DATA_W-1:0]    cmd_wdata_in,
    input  wire logic [asbla_pkg::LANE_W-1:0]    cmd_lane_in,
    output logic                                 cmd_ready_out,
    output logic                                 rsp_valid_out,
    output logic      [asbla_pkg::DATA_W-1:0]    rsp_rdata_out,
    output logic                                 width_select_out,
    output logic      [asbla_pkg::WORD_ADDR_W-1:0] sram_addr_out,
    output logic                                 select_low_active_n_out,
    output logic                                 select_high_active_out,
    output logic                                 write_strobe_n_out,
    output logic                                 out_enable_n_out,
    output logic                                 upper_lane_en_n_out,
    output logic                                 lower_lane_en_n_out,
    input  wire logic [asbla_pkg::DATA_W-1:0]    data_in,
    output logic      [asbla_pkg::DATA_W-1:0]    data_out,
    output logic      [asbla_pkg::DATA_W-1:0]    data_oe_n_out
);
    import asbla_pkg::*;

    asbla_state_e         state_reg;
    asbla_state_e         state_next;
    logic [CNT_W-1:0]     cnt_reg;
    logic                 word_mode_reg;
    logic [ADDR_W-1:0]    addr_reg;
    logic [DATA_W-1:0]    wdata_reg;
    logic [LANE_W-1:0]    lane_reg;
    logic                 write_reg;
    logic                 accept;
    logic [ADDR_W-1:0]    cur_addr;
    logic [DATA_W-1:0]    cur_wdata;
    logic [LANE_W-1:0]    cur_lane;
    logic                 cur_write;
    logic                 active_next;
    logic                 wr_next;
    logic [DATA_W-1:0]    data_sync;

    // ************************************************************
    // Data pin drive enables, active low
    // ************************************************************
    function automatic logic [DATA_W-1:0] drive_mask_n(input logic word_mode,
                                                       input logic wr,
                                                       input logic [LANE_W-1:0] lanes);
        logic [DATA_W-1:0] m;
        m = OE_N_OFF;
        if (word_mode)
        begin
            // RULE5 lower lane data
            m[BYTE_W-1:0] = {BYTE_W{!(wr && lanes[0])}};
            // RULE6 upper lane data
            m[DATA_W-1:BYTE_W] = {BYTE_W{!(wr && lanes[1])}};
        end
        else
        begin
            // RULE11 byte lane, address pin
            m[BYTE_W-1:0] = {BYTE_W{!wr}};
            m[TOP_BIT] = 1'b0;
        end
        return m;
    endfunction : drive_mask_n

    // ************************************************************
    // Data pin synchroniser
    // ************************************************************
    asbla_sync #(.WIDTH(DATA_W)) u_sync
    (
        .core_clk_in (core_clk_in),
        .reset_in    (reset_in),
        .async_in    (data_in),
        .sync_out    (data_sync)
    );

    // ************************************************************
    // Width strap
    // ************************************************************
    // RULE10 strap caught in reset
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
            word_mode_reg <= width_word_in;
        width_select_out <= word_mode_reg;
    end

    // ************************************************************
    // Command capture
    // ************************************************************
    assign accept    = cmd_ready_out && cmd_valid_in;
    assign cur_addr  = accept ? cmd_addr_in : addr_reg;
    assign cur_wdata = accept ? cmd_wdata_in : wdata_reg;
    assign cur_lane  = accept ? cmd_lane_in : lane_reg;
    assign cur_write = accept ? cmd_write_in : write_reg;

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            addr_reg  <= '0;
            wdata_reg <= DATA_ZERO;
            lane_reg  <= '0;
            write_reg <= 1'b0;
        end
        else if (accept)
        begin
            addr_reg  <= cmd_addr_in;
            wdata_reg <= cmd_wdata_in;
            lane_reg  <= cmd_lane_in;
            write_reg <= cmd_write_in;
        end
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
                if (accept)
                    state_next = cur_write ? ST_WR_SETUP : ST_RD_ACT;
            ST_RD_ACT:
                if (cnt_reg == RD_LAST_CNT)
                    state_next = ST_IDLE;
            ST_WR_SETUP:
                state_next = ST_WR_PULSE;
            ST_WR_PULSE:
                if (cnt_reg == WR_LAST_CNT)
                    state_next = ST_WR_HOLD;
            ST_WR_HOLD:
                state_next = ST_IDLE;
            default:
                state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            state_reg <= ST_IDLE;
            cnt_reg   <= '0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg   <= (state_next != state_reg) ? '0 : cnt_reg + CNT_W'(1);
        end
    end

    assign active_next = (state_next != ST_IDLE);
    assign wr_next     = (state_next == ST_WR_SETUP) || (state_next == ST_WR_PULSE) ||
                         (state_next == ST_WR_HOLD);

    // ************************************************************
    // Memory control pins
    // ************************************************************
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            select_low_active_n_out <= 1'b1;
            select_high_active_out  <= 1'b0;
            write_strobe_n_out      <= 1'b1;
            out_enable_n_out        <= 1'b1;
            upper_lane_en_n_out     <= 1'b1;
            lower_lane_en_n_out     <= 1'b1;
            sram_addr_out           <= '0;
        end
        else
        begin
            // RULE2 deselect between accesses
            select_low_active_n_out <= !active_next;
            select_high_active_out  <= active_next;
            // RULE4 strobe inside selection
            write_strobe_n_out      <= !(state_next == ST_WR_PULSE);
            // RULE7 read enable, strobe high
            out_enable_n_out        <= !(state_next == ST_RD_ACT);
            // RULE12 lane mask per access
            upper_lane_en_n_out     <= !(word_mode_reg && active_next && cur_lane[1]);
            lower_lane_en_n_out     <= !(word_mode_reg && active_next && cur_lane[0]);
            sram_addr_out           <= cur_addr[WORD_ADDR_W-1:0];
        end
    end

    // ************************************************************
    // Data pins
    // ************************************************************
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            data_out      <= DATA_ZERO;
            data_oe_n_out <= OE_N_OFF;
        end
        else
        begin
            // RULE3 no drive while reading, except the top pin in byte mode
            data_oe_n_out <= drive_mask_n(word_mode_reg, wr_next, cur_lane);
            data_out[TOP_BIT-1:0] <= cur_wdata[TOP_BIT-1:0];
            // RULE11 top pin carries address
            data_out[TOP_BIT] <= word_mode_reg ? cur_wdata[TOP_BIT] : cur_addr[ADDR_W-1];
        end
    end

    // ************************************************************
    // Handshake and read data
    // ************************************************************
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            cmd_ready_out <= 1'b0;
            rsp_valid_out <= 1'b0;
            rsp_rdata_out <= DATA_ZERO;
        end
        else
        begin
            cmd_ready_out <= (state_next == ST_IDLE);
            rsp_valid_out <= (state_reg == ST_RD_ACT) && (cnt_reg == RD_LAST_CNT);
            if ((state_reg == ST_RD_ACT) && (cnt_reg == RD_LAST_CNT))
            begin
                if (word_mode_reg)
                begin
                    // RULE1 sixteen-bit word read
                    rsp_rdata_out <= {lane_reg[1] ? data_sync[DATA_W-1:BYTE_W] : BYTE_ZERO,
                                      lane_reg[0] ? data_sync[BYTE_W-1:0] : BYTE_ZERO};
                end
                else
                begin
                    rsp_rdata_out <= {BYTE_ZERO, data_sync[BYTE_W-1:0]};
                end
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);

    property p_write_selected;
        !write_strobe_n_out |-> !select_low_active_n_out && select_high_active_out && out_enable_n_out;
    endproperty
    a_write_selected: assert property (p_write_selected) else $error("Strobe low while not selected"); // RULE4

    property p_write_pulse;
        $fell(write_strobe_n_out) |=> write_strobe_n_out && !select_low_active_n_out;
    endproperty
    a_write_pulse: assert property (p_write_pulse) else $error("Write pulse length or hold wrong"); // RULE4

    property p_read_pins;
        !out_enable_n_out |-> write_strobe_n_out && !select_low_active_n_out && select_high_active_out;
    endproperty
    a_read_pins: assert property (p_read_pins) else $error("Read without selects or strobe high"); // RULE7

    property p_read_float;
        !out_enable_n_out && word_mode_reg |-> (data_oe_n_out == OE_N_OFF);
    endproperty
    a_read_float: assert property (p_read_float) else $error("Host drives data during read"); // RULE7

    property p_read_answer;
        accept && !cmd_write_in |=> !rsp_valid_out [*3] ##1 rsp_valid_out;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("Read answer not on fourth cycle"); // RULE7

    property p_word_strap;
        word_mode_reg && !select_low_active_n_out |-> width_select_out;
    endproperty
    a_word_strap: assert property (p_word_strap) else $error("Word access with strap low"); // RULE10

    property p_byte_unused;
        !word_mode_reg |-> upper_lane_en_n_out && lower_lane_en_n_out && (&data_oe_n_out[TOP_BIT-1:BYTE_W]);
    endproperty
    a_byte_unused: assert property (p_byte_unused) else $error("Unused pins driven in byte mode"); // RULE11

    property p_byte_addr_stable;
        !word_mode_reg && !select_low_active_n_out && $past(!select_low_active_n_out)
            |-> $stable(data_out[TOP_BIT]) && !data_oe_n_out[TOP_BIT];
    endproperty
    a_byte_addr_stable: assert property (p_byte_addr_stable) else $error("Top address bit moved in access"); // RULE11

endmodule : asbla_host

// file: asbla_sram_model.sv
// Behavioural model of the asynchronous SRAM seen by the host controller.
// Assumes the bench resolves the shared data pins from both drive enables.
`timescale 1ns/100ps
module asbla_sram_model
(
    input  wire logic                              width_select_in,
    input  wire logic [asbla_pkg::WORD_ADDR_W-1:0] addr_in,
    input  wire logic                              select_low_active_n_in,
    input  wire logic                              select_high_active_in,
    input  wire logic                              write_strobe_n_in,
    input  wire logic                              out_enable_n_in,
    input  wire logic                              upper_lane_en_n_in,
    input  wire logic                              lower_lane_en_n_in,
    input  wire logic [asbla_pkg::DATA_W-1:0]      data_in,
    output logic      [asbla_pkg::DATA_W-1:0]      data_out,
    output logic      [asbla_pkg::DATA_W-1:0]      data_oe_n_out
);
    import asbla_pkg::*;

    logic [DATA_W-1:0] word_mem [0:(1 << WORD_ADDR_W) - 1];
    logic [BYTE_W-1:0] byte_mem [0:(1 << ADDR_W) - 1];
    logic              active;
    logic [ADDR_W-1:0] byte_addr;
    logic [DATA_W-1:0] word;

    assign byte_addr = {data_in[TOP_BIT], addr_in};
    assign active = !select_low_active_n_in && select_high_active_in
                    && (!width_select_in || !(upper_lane_en_n_in && lower_lane_en_n_in));

    // ************************************************************
    // Store at end of write pulse
    // ************************************************************
    always @(posedge write_strobe_n_in)
    begin
        if (active && !width_select_in)
            byte_mem[byte_addr] = data_in[7:0];
        if (active && width_select_in)
        begin
            word = word_mem[addr_in];
            if (!lower_lane_en_n_in)
                word[7:0] = data_in[7:0];
            if (!upper_lane_en_n_in)
                word[15:8] = data_in[15:8];
            word_mem[addr_in] = word;
        end
    end

    // ************************************************************
    // Read drive
    // ************************************************************
    always @*
    begin
        data_out      = DATA_ZERO;
        data_oe_n_out = OE_N_OFF;
        if (active && !out_enable_n_in && write_strobe_n_in)
        begin
            if (width_select_in)
            begin
                data_out = word_mem[addr_in];
                data_oe_n_out = {{8{upper_lane_en_n_in}}, {8{lower_lane_en_n_in}}};
            end
            else
            begin
                data_out[7:0]      = byte_mem[byte_addr];
                data_oe_n_out[7:0] = BYTE_ZERO;
            end
        end
    end

endmodule : asbla_sram_model

// file: async_sram_byte_lane_array_test.sv
// Self-checking bench for the SRAM host controller.
// Assumes the SRAM model on the pins and a 10 MHz core clock.
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("Error at %0t ns: got %h expected %h", $time, (g), (e)); end end
module async_sram_byte_lane_array_test;
    import asbla_pkg::*;

    logic              clk = 0, rst = 1, width_word = 1, cmd_valid = 0, cmd_write = 0;
    logic [ADDR_W-1:0] cmd_addr = '0;
    logic [DATA_W-1:0] cmd_wdata = '0, rdata, q;
    logic [LANE_W-1:0] cmd_lane = '0;
    logic              ready, rsp_valid, width_sel, sel_n, sel_h, strobe_n, oe_n, up_n, lo_n;
    logic [WORD_ADDR_W-1:0] addr;
    logic [DATA_W-1:0] h_data, h_oe_n, m_data, m_oe_n, pins, float_pat = 16'h5a3c;
    int                err_total = 0, n_tests = 0, k;

    always #50 clk = ~clk;
    // Undriven pins show a pattern that flips every cycle
    always @(posedge clk) float_pat <= ~float_pat;
    assign pins = (~h_oe_n & h_data) | (h_oe_n & ~m_oe_n & m_data) | (h_oe_n & m_oe_n & float_pat);

    asbla_host i_dut (.core_clk_in(clk), .reset_in(rst), .width_word_in(width_word),
        .cmd_valid_in(cmd_valid), .cmd_write_in(cmd_write), .cmd_addr_in(cmd_addr),
        .cmd_wdata_in(cmd_wdata), .cmd_lane_in(cmd_lane), .cmd_ready_out(ready),
        .rsp_valid_out(rsp_valid), .rsp_rdata_out(rdata), .width_select_out(width_sel),
        .sram_addr_out(addr), .select_low_active_n_out(sel_n), .select_high_active_out(sel_h),
        .write_strobe_n_out(strobe_n), .out_enable_n_out(oe_n), .upper_lane_en_n_out(up_n),
        .lower_lane_en_n_out(lo_n), .data_in(pins), .data_out(h_data), .data_oe_n_out(h_oe_n));

    asbla_sram_model i_mem (.width_select_in(width_sel), .addr_in(addr),
        .select_low_active_n_in(sel_n), .select_high_active_in(sel_h),
        .write_strobe_n_in(strobe_n), .out_enable_n_in(oe_n), .upper_lane_en_n_in(up_n),
        .lower_lane_en_n_in(lo_n), .data_in(pins), .data_out(m_data), .data_oe_n_out(m_oe_n));

    always @(posedge clk) if (!rst) `CHK(h_oe_n | m_oe_n, OE_N_OFF)

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out

    task automatic do_reset(input logic w);
        @(posedge clk); #1;
        rst = 1; width_word = w;
        repeat (10) @(posedge clk);
        #1 rst = 0;
    endtask : do_reset

    task automatic op(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      input logic [LANE_W-1:0] ln);
        k = 0;
        while (ready !== 1'b1 && k < 20)
        begin
            @(posedge clk); #1; k++;
        end
        if (k >= 20) `CHK(ready, 1'b1)
        cmd_valid = 1; cmd_write = wr; cmd_addr = a; cmd_wdata = d; cmd_lane = ln;
        @(posedge clk); #1;
        cmd_valid = 0;
        k = 0;
        while (!wr && rsp_valid !== 1'b1 && k < 20)
        begin
            @(posedge clk); #1; k++;
        end
        if (k >= 20) `CHK(1'b0, 1'b1)
        q = rdata;
        if (!wr)
        begin
            @(posedge clk); #1;
            `CHK(rsp_valid, 1'b0)
        end
    endtask : op

    task automatic t_idle();
        do_reset(1'b1);
        @(posedge clk); #1;
        `CHK({sel_n, sel_h, up_n, lo_n, h_oe_n}, {4'b1011, OE_N_OFF})
        `CHK(width_sel, 1'b1)
        $display("t_idle done");
    endtask : t_idle

    task automatic t_word();
        op(1, 22'h000000, 16'h1357, 2'b11);
        op(1, 22'h1fffff, 16'hfedc, 2'b11);
        op(0, 22'h000000, 16'h0000, 2'b11);
        `CHK(q, 16'h1357)
        op(0, 22'h1fffff, 16'h0000, 2'b11);
        `CHK(q, 16'hfedc)
        $display("t_word done");
    endtask : t_word

    task automatic t_lanes();
        op(1, 22'h000123, 16'h1234, 2'b11);
        op(1, 22'h000123, 16'hffab, 2'b01);
        op(0, 22'h000123, 16'h0000, 2'b11);
        `CHK(q, 16'h12ab)
        op(1, 22'h000123, 16'hcdff, 2'b10);
        op(0, 22'h000123, 16'h0000, 2'b11);
        `CHK(q, 16'hcdab)
        op(0, 22'h000123, 16'h0000, 2'b01);
        `CHK(q, 16'h00ab)
        op(0, 22'h000123, 16'h0000, 2'b10);
        `CHK(q, 16'hcd00)
        op(1, 22'h000123, 16'h0000, 2'b00);
        op(0, 22'h000123, 16'h0000, 2'b11);
        `CHK(q, 16'hcdab)
        $display("t_lanes done");
    endtask : t_lanes

    task automatic t_refused();
        int n;
        n = 0;
        cmd_valid = 1; cmd_write = 1; cmd_addr = 22'h000777; cmd_wdata = 16'h4242; cmd_lane = 2'b11;
        @(posedge clk); #1;
        cmd_write = 0; cmd_addr = 22'h000123;
        repeat (2) @(posedge clk);
        #1 cmd_valid = 0;
        repeat (8)
        begin
            @(posedge clk); #1;
            if (rsp_valid === 1'b1) n++;
        end
        `CHK(n, 0)
        op(0, 22'h000777, 16'h0000, 2'b11);
        `CHK(q, 16'h4242)
        $display("t_refused done");
    endtask : t_refused

    task automatic t_byte();
        do_reset(1'b0);
        op(1, 22'h000010, 16'hff5a, 2'b00);
        `CHK({width_sel, up_n, lo_n}, 3'b011)
        op(1, 22'h200010, 16'h00a5, 2'b00);
        op(0, 22'h000010, 16'h0000, 2'b00);
        `CHK(q, 16'h005a)
        op(0, 22'h200010, 16'h0000, 2'b11);
        `CHK(q, 16'h00a5)
        $display("t_byte done");
    endtask : t_byte

    initial
    begin
        #(3000 * 100);
        err_total++;
        close_out();
    end

    initial
    begin
        t_idle();
        t_word();
        t_lanes();
        t_refused();
        t_byte();
        close_out();
    end

endmodule : async_sram_byte_lane_array_test
